/* osc_ctrl.sv */
`timescale 1ns/1ps
`include "osc_ctrl_regs.svh"
// oscillator control registers on the special-function register port
module osc_ctrl
    import osc_ctrl_pkg::*;
#(
    parameter int TRIM_W = 7                  // calibration trim width
) (
    input  wire logic              i_sys_clk,         // system clock, 40 MHz
    input  wire logic              i_arst_n,          // async reset, active low
    input  wire logic [7:0]        i_sfr_addr,        // register address
    input  wire logic              i_sfr_wr,          // write strobe, one cycle
    input  wire logic [7:0]        i_sfr_wdata,       // write data
    input  wire logic              i_sfr_rd,          // read strobe, one cycle
    output logic      [7:0]        o_sfr_rdata,       // read data, registered
    output logic                   o_sfr_hit,         // read hit this block
    input  wire logic [TRIM_W-1:0] i_factory_trim,    // factory trim strap
    input  wire logic              i_int_osc_running, // oscillator at frequency
    input  wire logic              i_ext_osc_stable,  // external stable detector
    input  wire logic [2:0]        i_system_clock_source_select, // system clock source
    output logic                   o_internal_osc_enable,        // run internal osc
    output logic                   o_spread_spectrum_enable,     // dithering on
    output logic      [TRIM_W-1:0] o_internal_trim_field,        // trim to oscillator
    output logic      [2:0]        o_external_mode_field,        // effective mode
    output logic                   o_external_osc_enable,        // external circuit on
    output logic      [2:0]        o_external_bias_control,      // bias current level
    output logic                   o_int_drives_sysclk,          // internal is source
    output logic                   o_ext_drives_sysclk           // external is source
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic              int_en_r;                // internal enable
    logic              spread_r;                // spread spectrum enable
    logic [TRIM_W-1:0] trim_r;                  // calibration trim
    logic              trim_loaded_r;           // trim loaded, from strap or by a write
    logic [1:0]        load_cnt_r;              // waits for strap synchroniser
    logic [2:0]        mode_r;                  // stored mode field
    logic [2:0]        bias_r;                  // stored bias field
    logic [2:0]        mode_out_r;              // effective mode driven out
    logic              ext_on_r;                // external circuit enable out
    logic [7:0]        rdata_r;                 // read data register
    logic              hit_r;                   // read hit register
    logic [TRIM_W-1:0] trim_sync;               // synchronised strap
    logic              running_sync;            // synchronised running
    logic              stable_sync;             // synchronised stable

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    osc_sync #(.WIDTH(TRIM_W + 2)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_async   ({i_factory_trim, i_int_osc_running, i_ext_osc_stable}),
        .o_sync    ({trim_sync, running_sync, stable_sync})
    );

    // address match, used by both write and read paths
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    // reserved code 111 folds to the disabled code
    function automatic logic [2:0] fold_mode(input logic [2:0] m);
        fold_mode = (m == `EXT_MODE_RESERVED) ? `EXT_MODE_RESET : m;
    endfunction

    // mode code to circuit; 00x and the reserved code are off
    function automatic ext_mode_e decode_mode(input logic [2:0] m);
        case (m)
            `EXT_MODE_CMOS:      decode_mode = ext_cmos;
            `EXT_MODE_CMOS_DIV2: decode_mode = ext_cmos_div2;
            `EXT_MODE_RC:        decode_mode = ext_rc;
            `EXT_MODE_CAP:       decode_mode = ext_cap;
            `EXT_MODE_XTAL_DIV2: decode_mode = ext_xtal_div2;
            default:             decode_mode = ext_off;
        endcase
    endfunction

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    wire sel_ext  = addr_is(i_sfr_addr, `EXT_OSC_CONTROL_ADDR);
    wire sel_int  = addr_is(i_sfr_addr, `INT_OSC_CONTROL_ADDR);
    wire sel_cal  = addr_is(i_sfr_addr, `INT_OSC_CALIB_ADDR);
    wire wr_ext   = i_sfr_wr && sel_ext;
    wire wr_int   = i_sfr_wr && sel_int;
    wire wr_cal   = i_sfr_wr && sel_cal;
    wire any_sel  = sel_ext || sel_int || sel_cal;

    // mode field of the byte being written
    wire [2:0] wr_mode = i_sfr_wdata[`EXT_MODE_MSB:`EXT_MODE_LSB];
    ext_mode_e wr_mode_e;                       // circuit the write asks for
    ext_mode_e mode_e;                          // circuit now stored
    // mode field decode, one table for both
    assign wr_mode_e = decode_mode(wr_mode);
    // stored reserved code decodes as off
    assign mode_e    = decode_mode(mode_r);
    wire ext_on   = (mode_e != ext_off);
    wire ext_cmos_mode = (mode_e == ext_cmos) || (mode_e == ext_cmos_div2);
    // valid only while running and stable
    wire ext_valid = ext_on && !ext_cmos_mode && stable_sync;
    // ready only while enabled and at frequency
    wire int_ready = int_en_r && running_sync;

    // read images; reserved bits are fixed, not stored
    wire [7:0] int_image;
    wire [7:0] cal_image;
    wire [7:0] ext_image;
    // low six bits read fixed pattern
    assign int_image = {int_en_r, int_ready, `INT_RSVD_VALUE};
    assign cal_image = {spread_r, trim_r};
    // bit 3 reads zero, bit 6 reads zero
    assign ext_image = {ext_valid, 1'b0, mode_r[1:0], 1'b0, bias_r};
    wire [7:0] rd_mux = sel_ext ? ext_image :
                        sel_int ? int_image :
                        sel_cal ? cal_image : 8'h00;

    // ----------------------------------------
    // internal oscillator control register
    // ----------------------------------------
    // reserved write bits are dropped; software keeps them by read-modify-write
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_en_r <= 1'b0;
        end else if (wr_int) begin
            int_en_r <= i_sfr_wdata[`INT_ENABLE_BIT];
        end
    end

    // ----------------------------------------
    // calibration register
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            spread_r <= 1'b0;
        end else if (wr_cal) begin
            spread_r <= i_sfr_wdata[`CAL_SPREAD_BIT];
        end
    end

    // strap is caught after reset, once the synchroniser has filled
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            load_cnt_r <= 2'h0;
        end else if (load_cnt_r != `TRIM_LOAD_DELAY) begin
            load_cnt_r <= load_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            trim_r        <= '0;
            trim_loaded_r <= 1'b0;
        end else if (wr_cal) begin
            // trim passed straight to the oscillator
            trim_r        <= i_sfr_wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
            trim_loaded_r <= 1'b1;
        end else if (!trim_loaded_r && load_cnt_r == `TRIM_LOAD_DELAY) begin
            trim_r        <= trim_sync;
            trim_loaded_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // external oscillator control register
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_r <= `EXT_MODE_RESET;
            bias_r <= `EXT_BIAS_RESET;
        end else if (wr_ext) begin
            mode_r <= wr_mode;
            bias_r <= i_sfr_wdata[`EXT_BIAS_MSB:`EXT_BIAS_LSB];
        end
    end

    // ----------------------------------------
    // external oscillator outputs
    // ----------------------------------------
    // kept in flops apart from the readback copy, so the oscillator pads
    // never see a decode glitch while a mode write settles
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_out_r <= `EXT_MODE_RESET;
            ext_on_r   <= 1'b0;
        end else if (wr_ext) begin
            // reserved code drives the disabled code
            mode_out_r <= fold_mode(wr_mode);
            // circuit powered only for a listed mode
            ext_on_r   <= (wr_mode_e != ext_off);
        end
    end

    // ----------------------------------------
    // read port, one cycle behind the strobe
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_r <= 8'h00;
            hit_r   <= 1'b0;
        end else begin
            rdata_r <= i_sfr_rd ? rd_mux : 8'h00;
            hit_r   <= i_sfr_rd && any_sel;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_sfr_rdata              = rdata_r;
    assign o_sfr_hit                = hit_r;
    assign o_internal_osc_enable    = int_en_r;
    assign o_spread_spectrum_enable = spread_r;
    assign o_internal_trim_field    = trim_r;
    assign o_external_mode_field    = mode_out_r;
    assign o_external_osc_enable    = ext_on_r;
    assign o_external_bias_control  = bias_r;
    assign o_int_drives_sysclk = (i_system_clock_source_select == `CLK_SEL_INTERNAL);
    assign o_ext_drives_sysclk = (i_system_clock_source_select == `CLK_SEL_EXTERNAL);
endmodule

/* osc_ctrl_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// register port and control output checker
// ----------------------------------------
module osc_ctrl_monitor #(
    parameter int TRIM_W = 7                          // trim width
) (
    input wire logic              i_sys_clk,                    // clock
    input wire logic              i_arst_n,                     // reset, low
    input wire logic [7:0]        i_sfr_addr,                   // address
    input wire logic              i_sfr_wr,                     // write
    input wire logic [7:0]        i_sfr_wdata,                  // write data
    input wire logic              i_sfr_rd,                     // read
    input wire logic [7:0]        o_sfr_rdata,                  // read data
    input wire logic              o_sfr_hit,                    // read hit
    input wire logic [2:0]        i_system_clock_source_select, // source
    input wire logic              o_internal_osc_enable,        // enable
    input wire logic [TRIM_W-1:0] o_internal_trim_field,        // trim
    input wire logic [2:0]        o_external_mode_field,        // mode
    input wire logic              o_external_osc_enable,        // ext on
    input wire logic              o_int_drives_sysclk,          // int source
    input wire logic              o_ext_drives_sysclk           // ext source
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // decode of the three register addresses
    wire rd_int = i_sfr_rd && i_sfr_addr == 8'hb2;
    wire rd_ext = i_sfr_rd && i_sfr_addr == 8'hb1;
    wire mapped = i_sfr_addr inside {8'hb1, 8'hb2, 8'hb3};
    a_read_hit: assert property (i_sfr_rd && mapped |=> o_sfr_hit)
        else $error("mapped read gave no hit");
    a_unmapped_zero: assert property (i_sfr_rd && !mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    a_int_rsvd_bits: assert property (rd_int |=> o_sfr_rdata[5:0] == 6'h0f)
        else $error("internal low bits wrong");
    a_ready_needs_run: assert property (rd_int && !o_internal_osc_enable |=> o_sfr_rdata[7:6] == 2'b00)
        else $error("ready shown while stopped");
    a_enable_follows: assert property (i_sfr_wr && i_sfr_addr == 8'hb2
        |=> o_internal_osc_enable == $past(i_sfr_wdata[7]))
        else $error("enable did not follow write");
    a_trim_follows: assert property (i_sfr_wr && i_sfr_addr == 8'hb3
        |=> o_internal_trim_field == $past(i_sfr_wdata[TRIM_W-1:0]))
        else $error("trim did not follow write");
    a_ext_fixed_zero: assert property (rd_ext |=> !o_sfr_rdata[6] && !o_sfr_rdata[3])
        else $error("external fixed bits not zero");
    a_cmos_no_valid: assert property (rd_ext && o_external_mode_field[2:1] == 2'b01
        |=> !o_sfr_rdata[7])
        else $error("valid shown in clock input mode");
    a_mode_enable: assert property (o_external_mode_field != 3'h7 &&
        o_external_osc_enable == (o_external_mode_field[2:1] != 2'b00))
        else $error("external enable disagrees with mode");
    a_source_decode: assert property (o_int_drives_sysclk == (i_system_clock_source_select == 3'h0)
        && o_ext_drives_sysclk == (i_system_clock_source_select == 3'h1))
        else $error("clock source decode wrong");
endmodule
bind osc_ctrl osc_ctrl_monitor #(.TRIM_W(TRIM_W)) mon_u (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
    .i_system_clock_source_select(i_system_clock_source_select),
    .o_internal_osc_enable(o_internal_osc_enable), .o_internal_trim_field(o_internal_trim_field),
    .o_external_mode_field(o_external_mode_field), .o_external_osc_enable(o_external_osc_enable),
    .o_int_drives_sysclk(o_int_drives_sysclk), .o_ext_drives_sysclk(o_ext_drives_sysclk));

/* osc_ctrl_pkg.sv */
package osc_ctrl_pkg;
    // external circuit modes, decoded from the mode field
    typedef enum logic [2:0] {
        ext_off,
        ext_cmos,
        ext_cmos_div2,
        ext_rc,
        ext_cap,
        ext_xtal_div2
    } ext_mode_e;
endpackage

/* osc_ctrl_regs.svh */
`ifndef OSC_CTRL_REGS_SVH
`define OSC_CTRL_REGS_SVH
// Function
// - internal enable bit runs or stops oscillator
// - read-only ready flag at internal bit 6
// - internal low six bits read 001111b
// - calibration bit 7 enables spread spectrum
// - seven-bit trim resets to factory value
// - higher trim lowers frequency, about 1%
// - external valid flag read-only at bit 7
// - valid flag zero in CMOS clock modes
// - mode field 6:4 selects external circuit
// - external bit 3 reads zero always
// - bias field 2:0 resets to zero
// - clock select 000 internal, 001 external

// ----------------------------------------
// register addresses
// ----------------------------------------
`define EXT_OSC_CONTROL_ADDR   8'hb1
`define INT_OSC_CONTROL_ADDR   8'hb2
`define INT_OSC_CALIB_ADDR     8'hb3

// ----------------------------------------
// field positions
// ----------------------------------------
`define INT_ENABLE_BIT         7
`define INT_READY_BIT          6
`define INT_RSVD_MSB           5
`define INT_RSVD_LSB           0
`define CAL_SPREAD_BIT         7
`define CAL_TRIM_MSB           6
`define CAL_TRIM_LSB           0
`define EXT_VALID_BIT          7
`define EXT_MODE_MSB           6
`define EXT_MODE_LSB           4
`define EXT_RSVD_BIT           3
`define EXT_BIAS_MSB           2
`define EXT_BIAS_LSB           0

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define INT_RSVD_VALUE         6'h0f
`define EXT_BIAS_RESET         3'h0
`define EXT_MODE_RESET         3'h0
`define CLK_SEL_INTERNAL       3'h0
`define CLK_SEL_EXTERNAL       3'h1
`define TRIM_LOAD_DELAY        2'h2

// ----------------------------------------
// external mode codes
// ----------------------------------------
`define EXT_MODE_CMOS          3'h2
`define EXT_MODE_CMOS_DIV2     3'h3
`define EXT_MODE_RC            3'h4
`define EXT_MODE_CAP           3'h5
`define EXT_MODE_XTAL_DIV2     3'h6
`define EXT_MODE_RESERVED      3'h7

`endif

/* osc_model.sv */
`timescale 1ns/1ps
// oscillator pair; both need a startup time before they report good
module osc_model #(
    parameter int START_CYC = 6                   // startup in cycles
) (
    input  wire logic i_sys_clk,                  // clock
    input  wire logic i_arst_n,                   // reset, low
    input  wire logic i_int_en,                   // internal run request
    input  wire logic i_ext_en,                   // external circuit on
    output logic      o_int_running,              // internal at frequency
    output logic      o_ext_stable                // external settled
);
    int int_cnt;                                  // internal startup count
    int ext_cnt;                                  // external settle count
    // runs only while enabled, drops at once when stopped
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_cnt <= 0;
            ext_cnt <= 0;
        end else begin
            int_cnt <= !i_int_en ? 0 : (int_cnt < START_CYC ? int_cnt + 1 : int_cnt);
            ext_cnt <= !i_ext_en ? 0 : (ext_cnt < START_CYC ? ext_cnt + 1 : ext_cnt);
        end
    end
    assign o_int_running = int_cnt == START_CYC;
    // detector also fires in clock input modes, so the register must mask it
    assign o_ext_stable = ext_cnt == START_CYC;
endmodule

/* osc_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module osc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,  // system clock
    input  wire logic             i_arst_n,   // async reset, active low
    input  wire logic [WIDTH-1:0] i_async,    // unsynchronised level
    output logic      [WIDTH-1:0] o_sync      // synchronised level
);
    logic [WIDTH-1:0] meta_r;                 // first stage, read only by second

    // ----------------------------------------
    // two flip-flops in series
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
    logic       i_sys_clk = 1'b0;                 // 40 MHz clock
    logic       i_arst_n  = 1'b0;                 // reset, low
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       wr = 1'b0, rd = 1'b0, hit, running, stable, en, spread_spectrum_enable, ext_en, int_src, ext_src;
    logic [2:0] sel = 3'h0, mode, bias;
    logic [6:0] trim;
    int         n_errors = 0, samples_checked = 0, cycles = 0;
    localparam logic [6:0] STRAP = 7'h35;         // factory strap, arbitrary
    always #12.5 i_sys_clk = ~i_sys_clk;
    osc_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_factory_trim(STRAP), .i_int_osc_running(running), .i_ext_osc_stable(stable),
        .i_system_clock_source_select(sel), .o_internal_osc_enable(en),
        .o_spread_spectrum_enable(spread_spectrum_enable), .o_internal_trim_field(trim),
        .o_external_mode_field(mode), .o_external_osc_enable(ext_en),
        .o_external_bias_control(bias), .o_int_drives_sysclk(int_src),
        .o_ext_drives_sysclk(ext_src));
    osc_model osc_u (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_int_en(en),
        .i_ext_en(ext_en), .o_int_running(running), .o_ext_stable(stable));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge i_sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        check("hit", {7'h0, hit}, {7'h0, a inside {8'hb1, 8'hb2, 8'hb3}});
    endtask
    task automatic expect_reg(string name, logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        check(name, d, exp);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic s_reset_values();
        repeat (4) @(posedge i_sys_clk);
        expect_reg("int_ctrl", 8'hb2, 8'h0f);
        expect_reg("ext_ctrl", 8'hb1, 8'h00);
        expect_reg("calib", 8'hb3, {1'b0, STRAP});
    endtask
    task automatic s_internal();
        logic [7:0] d;
        rd_reg(8'hb2, d);
        wr_reg(8'hb2, d | 8'h80);
        check("enable", {7'h0, en}, 8'h01);
        expect_reg("starting", 8'hb2, 8'h8f);
        for (int i = 0; i < 20 && d !== 8'hcf; i++) rd_reg(8'hb2, d);
        check("ready", d, 8'hcf);
        wr_reg(8'hb2, 8'h4f);
        expect_reg("stopped", 8'hb2, 8'h0f);
    endtask
    task automatic s_calib();
        // move off the internal source, stop, retrim, restart
        @(posedge i_sys_clk);
        sel <= 3'h1;
        wr_reg(8'hb2, 8'h0f);
        // trim kept in the useful range
        wr_reg(8'hb3, 8'hc0);
        check("trim", {1'b0, trim}, 8'h40);
        check("spread", {7'h0, spread_spectrum_enable}, 8'h01);
        wr_reg(8'hb2, 8'h8f);
        expect_reg("calib", 8'hb3, 8'hc0);
        wr_reg(8'hb3, 8'h7f);
        check("spread", {7'h0, spread_spectrum_enable}, 8'h00);
    endtask
    task automatic s_source();
        for (int s = 0; s < 8; s++) begin
            @(posedge i_sys_clk);
            sel <= 3'(s);
            #1;
            check("int_src", {7'h0, int_src}, {7'h0, s == 0});
            check("ext_src", {7'h0, ext_src}, {7'h0, s == 1});
        end
    endtask
    task automatic s_external();
        logic [2:0] mm, em;
        for (int m = 0; m < 8; m++) begin
            mm = 3'(m);
            em = (mm == 3'h7) ? 3'h0 : mm;
            wr_reg(8'hb1, {1'b1, mm, 1'b0, ~mm});
            check("mode", {5'h0, mode}, {5'h0, em});
            check("ext_on", {7'h0, ext_en}, {7'h0, em[2:1] != 2'b00});
            check("bias", {5'h0, bias}, {5'h0, ~mm});
            repeat (12) @(posedge i_sys_clk);
            expect_reg("ext_ctrl", 8'hb1, {mm inside {3'h4, 3'h5, 3'h6}, 1'b0, mm[1:0],
                1'b0, ~mm});
        end
    endtask
    task automatic s_unmapped();
        wr_reg(8'hb4, 8'hff);
        wr_reg(8'hb0, 8'hff);
        expect_reg("unmapped", 8'hb4, 8'h00);
        expect_reg("unmapped", 8'hb0, 8'h00);
        expect_reg("calib", 8'hb3, 8'h7f);
    endtask
    task automatic s_reset_again();
        // mid-run reset restores every field and reloads the strap
        @(posedge i_sys_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        s_reset_values();
        check("mode_out", {5'h0, mode}, 8'h00);
        check("sse_out", {7'h0, spread_spectrum_enable}, 8'h00);
    endtask
    // cycle ceiling cuts a hang short
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        s_reset_values();
        s_internal();
        s_calib();
        s_source();
        s_external();
        s_unmapped();
        s_reset_again();
        close_out();
    end
endmodule
